// file: core/osc_flag_sync.sv
// two-flop synchroniser for the analog oscillator status flags
`timescale 1ns/1ps

module osc_flag_sync
    import osc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [osc_pkg::STATUS_BITS-1:0] flags_async,
    output logic [osc_pkg::STATUS_BITS-1:0] flags_sync
);

    typedef struct packed {
        logic [STATUS_BITS-1:0] meta;
        logic [STATUS_BITS-1:0] stable;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // ------------------------------------------------------------------
    // next state: meta is only ever read by the second stage
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = flags_async;
        s_nxt.stable = s_r.meta;
    end

    // flags come from free-running analog detectors, so both stages reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= {FLAGS_RESET, FLAGS_RESET};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign flags_sync = s_r.stable;

endmodule : osc_flag_sync

// file: core/osc_pkg.sv
// shared constants, field layout and helpers for the oscillator status block
package osc_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // ------------------------------------------------------------------
    // register byte addresses, one aligned word each
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_OSC_STATUS = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_FREQ_TRIM = 12'h004;

    // ------------------------------------------------------------------
    // oscillator status field positions
    // ------------------------------------------------------------------
    localparam int STATUS_BITS = 7;
    localparam int POS_PLL_READY = 6;
    localparam int POS_STARTUP = 5;
    localparam int POS_HF_READY = 4;
    localparam int POS_HF_LOCKED = 3;
    localparam int POS_MF_READY = 2;
    localparam int POS_LF_READY = 1;
    localparam int POS_HF_STABLE = 0;

    // ------------------------------------------------------------------
    // frequency trim field and reset values
    // ------------------------------------------------------------------
    localparam int TRIM_W = 6;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;
    localparam logic [TRIM_W-1:0] TRIM_MIN_CODE = 6'h20;
    localparam logic [TRIM_W-1:0] TRIM_MAX_CODE = 6'h1F;
    localparam logic [STATUS_BITS-1:0] FLAGS_RESET = 7'h00;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;

    // signed trim code to offset binary: most negative -> 0, most
    // positive -> all ones, zero -> mid scale; strictly monotonic
    function automatic logic [TRIM_W-1:0] to_offset_binary(
        input logic [TRIM_W-1:0] code);
        to_offset_binary = {~code[TRIM_W-1], code[TRIM_W-2:0]};
    endfunction : to_offset_binary

endpackage : osc_pkg

// file: core/osc_status_and_tuning.sv
// apb register block: oscillator status flags and frequency trim
`timescale 1ns/1ps

// How it works
// R1 - bit 5 high when running configured clock
// R2 - bit 3 high when hf within 2%
// R3 - bit 2 reports medium-frequency oscillator ready
// R4 - bit 1 reports low-frequency oscillator ready
// R5 - signed 6-bit trim, monotonic, zero is calibrated
// R6 - bit 4 hf ready, 0 stable, 6 pll
module osc_status_and_tuning
    import osc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [osc_pkg::ADDR_W-1:0] paddr,
    input wire logic [osc_pkg::DATA_W-1:0] pwdata,
    input wire logic [osc_pkg::STRB_W-1:0] pstrb,
    output logic [osc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pll_ready_flag,
    input wire logic startup_timer_status,
    input wire logic hf_osc_ready_flag,
    input wire logic hf_osc_locked_flag,
    input wire logic mf_osc_ready_flag,
    input wire logic lf_osc_ready_flag,
    input wire logic hf_osc_stable_flag,
    output logic [osc_pkg::TRIM_W-1:0] trim_level
);

    import osc_pkg::*;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
        logic [TRIM_W-1:0] frequency_trim_field;
    } regs_t;

    regs_t s_r;
    regs_t s_nxt;
    logic [STATUS_BITS-1:0] flags_raw;
    logic [STATUS_BITS-1:0] flags_sync;
    logic [TRIM_W-1:0] wr_trim;
    logic access_first;
    logic access_last;
    logic hit_status;
    logic hit_trim;

    // ------------------------------------------------------------------
    // status flag capture
    // ------------------------------------------------------------------

    // gather the analog flags at their status register positions
    always_comb begin
        flags_raw = FLAGS_RESET;
        flags_raw[POS_PLL_READY] = pll_ready_flag; // see R6
        flags_raw[POS_STARTUP] = startup_timer_status; // see R1
        flags_raw[POS_HF_READY] = hf_osc_ready_flag; // see R6
        flags_raw[POS_HF_LOCKED] = hf_osc_locked_flag; // see R2
        flags_raw[POS_MF_READY] = mf_osc_ready_flag; // see R3
        flags_raw[POS_LF_READY] = lf_osc_ready_flag; // see R4
        flags_raw[POS_HF_STABLE] = hf_osc_stable_flag; // see R6
    end

    osc_flag_sync u_flag_sync (
        .pclk(pclk),
        .presetn(presetn),
        .flags_async(flags_raw),
        .flags_sync(flags_sync)
    );

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------

    // one wait state: pready rises in the second access cycle
    assign access_first = psel && penable && !s_r.pready;
    assign access_last = psel && penable && s_r.pready;
    assign hit_status = (paddr == ADDR_OSC_STATUS);
    assign hit_trim = (paddr == ADDR_FREQ_TRIM);
    assign wr_trim = pwdata[TRIM_W-1:0];

    // ------------------------------------------------------------------
    // register next state
    // ------------------------------------------------------------------

    // read data is snapshotted on the first access cycle so it holds
    // steady while pready is high, even if a flag toggles meanwhile
    always_comb begin
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (access_first) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = RDATA_RESET;
            if (hit_status) begin
                if (!pwrite) begin
                    // bit 7 and above read as zero
                    s_nxt.prdata[STATUS_BITS-1:0] = flags_sync; // see R1
                end
            end else if (hit_trim) begin
                if (!pwrite) begin
                    s_nxt.prdata[TRIM_W-1:0] = s_r.frequency_trim_field;
                end
            end else begin
                s_nxt.pslverr = 1'b1; // unmapped address
            end
        end
        // the write lands at the edge where pready is sampled high
        if (access_last && pwrite && hit_trim && pstrb[0]) begin
            s_nxt.frequency_trim_field = wr_trim; // see R5
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.pready <= 1'b0;
            s_r.pslverr <= 1'b0;
            s_r.prdata <= RDATA_RESET;
            s_r.frequency_trim_field <= TRIM_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // trim output
    // ------------------------------------------------------------------

    // the dac gets offset binary, the register keeps the signed code
    osc_trim_map u_trim_map (
        .pclk(pclk),
        .presetn(presetn),
        .trim_code(s_r.frequency_trim_field),
        .trim_level(trim_level)
    );

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge pclk);
    endclocking

    default disable iff (!presetn);

    // first access cycle of a read to the status register
    sequence status_read_req;
        access_first && !pwrite && hit_status;
    endsequence

    // completing write to the trim register with its low lane enabled
    sequence trim_write_done;
        access_last && pwrite && hit_trim && pstrb[0];
    endsequence

    AST_STARTUP_FLAG: assert property ( // see R1
        status_read_req |=> pready
            && prdata[POS_STARTUP] == $past(flags_sync[POS_STARTUP]))
        else $error("startup status bit does not follow its source");

    AST_HF_LOCK: assert property ( // see R2
        status_read_req |=> pready
            && prdata[POS_HF_LOCKED] == $past(flags_sync[POS_HF_LOCKED]))
        else $error("hf lock bit does not follow its source");

    AST_MF_READY: assert property ( // see R3
        status_read_req |=> pready
            && prdata[POS_MF_READY] == $past(flags_sync[POS_MF_READY]))
        else $error("mf ready bit does not follow its source");

    AST_LF_READY: assert property ( // see R4
        status_read_req |=> pready
            && prdata[POS_LF_READY] == $past(flags_sync[POS_LF_READY]))
        else $error("lf ready bit does not follow its source");

    AST_HF_READY: assert property ( // see R6
        status_read_req |=> prdata[POS_HF_READY]
            == $past(flags_sync[POS_HF_READY])
            && prdata[POS_HF_STABLE] == $past(flags_sync[POS_HF_STABLE]))
        else $error("hf ready or stable bit does not follow its source");

    AST_PLL_READY: assert property ( // see R6
        status_read_req |=> prdata[POS_PLL_READY]
            == $past(flags_sync[POS_PLL_READY])
            && prdata[DATA_W-1:STATUS_BITS] == '0)
        else $error("pll ready bit wrong or upper status bits not zero");

    AST_TRIM_MAP: assert property ( // see R5
        trim_write_done |=> ##1 trim_level
            == to_offset_binary($past(wr_trim, 2)))
        else $error("trim level does not match the written signed code");

    AST_TRIM_ENDS: assert property ( // see R5
        (s_r.frequency_trim_field == TRIM_MIN_CODE) |=>
            (trim_level == '0) || $changed(s_r.frequency_trim_field))
        else $error("most negative trim code is not minimum level");

    // ------------------------------------------------------------------
    // register access checks
    // ------------------------------------------------------------------

    // first access cycle of a read to the trim register
    sequence trim_read_req;
        access_first && !pwrite && hit_trim;
    endsequence

    // first access cycle of a write to the trim register
    sequence trim_write_req;
        access_first && pwrite && hit_trim;
    endsequence

    // completing write to the trim register with its low lane disabled
    sequence trim_write_masked;
        access_last && pwrite && hit_trim && !pstrb[0];
    endsequence

    // first access cycle of a write to the read-only status register
    sequence status_write_req;
        access_first && pwrite && hit_status;
    endsequence

    // first access cycle to an address that maps no register
    sequence unmapped_req;
        access_first && !hit_status && !hit_trim;
    endsequence

    // trim reads back its signed code zero-extended to the word
    AST_TRIM_READBACK: assert property ( // see R5
        trim_read_req |=> pready && !pslverr
            && prdata == {{(DATA_W-TRIM_W){1'b0}},
                $past(s_r.frequency_trim_field)})
        else $error("trim read data differs from the stored code");

    // a write to the trim register is accepted without error
    AST_TRIM_WRITE_OK: assert property ( // see R5
        trim_write_req |=> pready && !pslverr)
        else $error("trim write answered with an error");

    // with byte lane 0 off, the stored code must not move
    AST_TRIM_MASKED: assert property ( // see R5
        trim_write_masked |=> $stable(s_r.frequency_trim_field))
        else $error("trim changed on a write with its lane disabled");

    // only a completing enabled write may change the stored code
    AST_TRIM_HOLDS: assert property ( // see R5
        !(access_last && pwrite && hit_trim && pstrb[0])
            |=> $stable(s_r.frequency_trim_field))
        else $error("trim changed without a write to it");

    // status is read-only: a write completes quietly and changes nothing
    AST_STATUS_RO: assert property ( // see R6
        status_write_req |=> pready && !pslverr)
        else $error("write to status answered with an error");

    // unmapped addresses answer with an error and zero data
    AST_UNMAPPED: assert property ( // see R6
        unmapped_req |=> pready && pslverr && prdata == '0)
        else $error("unmapped access not answered with an error");

    // the snapshot holds between accesses so a moving flag cannot tear it
    AST_PRDATA_STANDS: assert property ( // see R1
        !access_first |=> $stable(prdata))
        else $error("read data changed outside an access");

    // ------------------------------------------------------------------
    // trim level and flag path checks
    // ------------------------------------------------------------------

    // code zero is the calibrated point, the middle of the dac range
    AST_MID_SCALE: assert property ( // see R5
        (s_r.frequency_trim_field == TRIM_RESET)
            |=> trim_level == {1'b1, {(TRIM_W-1){1'b0}}})
        else $error("zero trim code is not mid scale");

    // the most positive code gives the top of the dac range
    AST_MAX_LEVEL: assert property ( // see R5
        (s_r.frequency_trim_field == TRIM_MAX_CODE) |=> trim_level == '1)
        else $error("most positive trim code is not maximum level");

    // a higher signed code never lowers the level: monotonic across zero
    AST_TRIM_RISES: assert property ( // see R5
        $signed(s_r.frequency_trim_field)
            > $signed($past(s_r.frequency_trim_field))
            |=> trim_level > $past(trim_level))
        else $error("trim level did not rise with the code");

    // a lower signed code never raises the level
    AST_TRIM_FALLS: assert property ( // see R5
        $signed(s_r.frequency_trim_field)
            < $signed($past(s_r.frequency_trim_field))
            |=> trim_level < $past(trim_level))
        else $error("trim level did not fall with the code");

    // each flag reaches the register two edges after it is sampled
    AST_FLAG_PATH: assert property ( // see R1
        $past(presetn, 2) |-> flags_sync == $past(flags_raw, 2))
        else $error("status flags do not pass two flops");

endmodule : osc_status_and_tuning

// file: core/osc_trim_map.sv
// maps the signed trim code onto the oscillator's trim level
`timescale 1ns/1ps

module osc_trim_map
    import osc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [osc_pkg::TRIM_W-1:0] trim_code,
    output logic [osc_pkg::TRIM_W-1:0] trim_level
);

    typedef struct packed {
        logic [TRIM_W-1:0] level;
    } map_state_t;

    map_state_t s_r;
    map_state_t s_nxt;

    // ------------------------------------------------------------------
    // offset binary keeps the analog trim dac monotonic across zero
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.level = to_offset_binary(trim_code); // see R5
    end

    // registered so the dac never sees a glitch from the bus logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= to_offset_binary(TRIM_RESET);
        end else begin
            s_r <= s_nxt;
        end
    end

    assign trim_level = s_r.level;

endmodule : osc_trim_map

// file: verif/osc_status_and_tuning_bench.sv
// self-checking bench for the oscillator status and trim register block
`timescale 1ns/1ps

module osc_status_and_tuning_bench;
    import osc_pkg::*;

    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [STATUS_BITS-1:0] flags;
    logic [TRIM_W-1:0] trim_level;
    logic [DATA_W-1:0] rd;
    logic err;
    int errors;
    int cmp_count;

    // flags vector order matches the status bit positions 6..0
    osc_status_and_tuning dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pll_ready_flag(flags[6]), .startup_timer_status(flags[5]),
        .hf_osc_ready_flag(flags[4]), .hf_osc_locked_flag(flags[3]),
        .mf_osc_ready_flag(flags[2]), .lf_osc_ready_flag(flags[1]),
        .hf_osc_stable_flag(flags[0]), .trim_level(trim_level)
    );

    // ------------------------------------------------------------------
    // clock, shared tasks
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : check

    // one apb transfer: setup just after a rising edge, access held until
    // pready is sampled high at a rising edge, where data and error are
    // taken; a hang is left to the watchdog rather than a local count
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_edges(input int k);
        repeat (k) @(posedge pclk);
    endtask : wait_edges

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // watchdog at 20000 cycles: the tests need well under 2000
    initial begin
        #(50 * 20000);
        errors = errors + 1;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        errors = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        flags = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values: trim code zero sits at mid scale
        apb(1'b0, ADDR_FREQ_TRIM, 32'h0, 4'hF, rd, err);
        check(rd, 32'h00000000);
        check({26'h0, trim_level}, 32'h00000020);
        $display("test reset values done");
        // each flag alone lands on its own status bit, upper bits read 0
        for (int i = 0; i < 7; i++) begin
            flags <= 7'h01 << i;
            wait_edges(3);
            apb(1'b0, ADDR_OSC_STATUS, 32'h0, 4'hF, rd, err);
            check(rd, 32'h1 << i);
        end
        // a write to the read-only status changes nothing
        flags <= 7'h55;
        wait_edges(3);
        apb(1'b1, ADDR_OSC_STATUS, 32'hFFFFFFFF, 4'hF, rd, err);
        check({31'h0, err}, 32'h0);
        apb(1'b0, ADDR_OSC_STATUS, 32'h0, 4'hF, rd, err);
        check(rd, 32'h00000055);
        $display("test status flags done");
        // signed trim: ascending codes -32..31 give a level rising by one
        for (int k = 0; k < 64; k++) begin
            apb(1'b1, ADDR_FREQ_TRIM, 32'(k ^ 32'h20), 4'h1, rd, err);
            wait_edges(2);
            check({26'h0, trim_level}, 32'(k));
        end
        apb(1'b0, ADDR_FREQ_TRIM, 32'h0, 4'hF, rd, err);
        check(rd, 32'h0000001F);
        // write with byte lane 0 off must not touch the trim
        apb(1'b1, ADDR_FREQ_TRIM, 32'h00000020, 4'hE, rd, err);
        apb(1'b0, ADDR_FREQ_TRIM, 32'h0, 4'hF, rd, err);
        check(rd, 32'h0000001F);
        // only bits 5:0 are kept; minimum code reads back exactly
        apb(1'b1, ADDR_FREQ_TRIM, 32'hFFFFFFE0, 4'hF, rd, err);
        apb(1'b0, ADDR_FREQ_TRIM, 32'h0, 4'hF, rd, err);
        check(rd, 32'h00000020);
        check({26'h0, trim_level}, 32'h00000000);
        $display("test trim done");
        // unmapped address answers with an error and zero data
        apb(1'b0, 12'h008, 32'h0, 4'hF, rd, err);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        // second reset mid-run restores trim and clears flags
        flags <= 7'h00;
        @(posedge pclk);
        presetn <= 1'b0;
        wait_edges(2);
        check({26'h0, trim_level}, 32'h00000020);
        presetn <= 1'b1;
        wait_edges(3);
        apb(1'b0, ADDR_FREQ_TRIM, 32'h0, 4'hF, rd, err);
        check(rd, 32'h0);
        apb(1'b0, ADDR_OSC_STATUS, 32'h0, 4'hF, rd, err);
        check(rd, 32'h0);
        $display("test errors and reset done");
        report_and_stop();
    end

endmodule : osc_status_and_tuning_bench
